//--- rtl/dcr_regs.svh
// Register map, field positions, reset values and timing counts
`ifndef DCR_REGS_SVH
`define DCR_REGS_SVH

`define DCR_OFF_CODE_CH0 7'h1b
`define DCR_OFF_CODE_CH1 7'h1c
`define DCR_OFF_LOW_CH2 7'h13
`define DCR_OFF_HIGH_CH2 7'h14
`define DCR_OFF_RAMP_CH2 7'h18
`define DCR_CODE_RST 16'h0000
`define DCR_RAMP_RST 16'h0000
`define DCR_CODE_MSB 15
`define DCR_CODE_LSB 4
`define DCR_FALL_MSB 3
`define DCR_FALL_LSB 1
`define DCR_RISE_MSB 6
`define DCR_RISE_LSB 4
`define DCR_LOGEN_BIT 7
`define DCR_DIR_BIT 15
`define DCR_LOG_SHIFT 5

`define DCR_CLK_MHZ 250
`define DCR_STEP0_NS 4000
`define DCR_STEP1_NS 12000
`define DCR_STEP2_NS 27040
`define DCR_STEP3_NS 60720
`define DCR_STEP4_NS 136720
`define DCR_STEP5_NS 418640
`define DCR_NS_TO_CYC(ns) (((ns) * `DCR_CLK_MHZ) / 1000)

`define DCR_FRAME_BITS 24
`define DCR_RD_BIT 23
`define DCR_HALF_CYC 8

`define DCR_WB_CMD 8'h00
`define DCR_WB_WDATA 8'h04
`define DCR_WB_RDATA 8'h08
`define DCR_WB_STAT 8'h0c
`define DCR_CMD_RD_BIT 8
`define DCR_STAT_BUSY_BIT 0
`define DCR_STAT_DONE_BIT 1

`endif

//--- rtl/dcr_pkg.sv
// Shared types for the code register bank and its controller
package dcr_pkg;
  typedef enum logic [1:0] {
    DCR_H_IDLE = 2'b00,
    DCR_H_SHIFT = 2'b01,
    DCR_H_GAP = 2'b10
  } dcr_host_state_t;
  typedef logic [11:0] dcr_code_t;
endpackage

//--- rtl/dcr_link_if.sv
// Serial link between controller and code register bank
`timescale 1ns/10ps
interface dcr_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport device (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

//--- rtl/dcr_device.sv
// Code register bank end: serial slave, code registers and log ramp
`timescale 1ns/10ps
`include "dcr_regs.svh"
module dcr_device #(
  parameter int CODE_BITS = 10,
  parameter int STEP_CYC_0 = `DCR_NS_TO_CYC(`DCR_STEP0_NS),
  parameter int STEP_CYC_1 = `DCR_NS_TO_CYC(`DCR_STEP1_NS),
  parameter int STEP_CYC_2 = `DCR_NS_TO_CYC(`DCR_STEP2_NS),
  parameter int STEP_CYC_3 = `DCR_NS_TO_CYC(`DCR_STEP3_NS),
  parameter int STEP_CYC_4 = `DCR_NS_TO_CYC(`DCR_STEP4_NS),
  parameter int STEP_CYC_5 = `DCR_NS_TO_CYC(`DCR_STEP5_NS)
) (
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  dcr_link_if.device LINK,
  output logic [CODE_BITS-1:0] CODE_CH0_O,
  output logic [CODE_BITS-1:0] CODE_CH1_O,
  output logic [CODE_BITS-1:0] CODE_CH2_O,
  output logic RAMP_BUSY_O
);

  // Keeps only the top CODE_BITS of the 12-bit field
  localparam dcr_pkg::dcr_code_t CODE_MASK = ~(12'hfff >> CODE_BITS);

  // Pin synchronisers
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic cs_s1_q, cs_s2_q;
  logic mosi_s1_q, mosi_s2_q;

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
    end else begin
      sclk_s1_q <= LINK.sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q <= LINK.cs_n;
      cs_s2_q <= cs_s1_q;
      mosi_s1_q <= LINK.mosi;
      mosi_s2_q <= mosi_s1_q;
    end
  end

  logic sclk_rise, sclk_fall;
  assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
  assign sclk_fall = ~sclk_s2_q & sclk_s3_q;

  // Register state
  dcr_pkg::dcr_code_t code0_q, code0_d, code1_q, code1_d;
  dcr_pkg::dcr_code_t low_q, low_d, high_q, high_d, code2_q, code2_d;
  logic [15:0] ramp_q, ramp_d;
  logic [16:0] tick_q, tick_d;
  logic busy_q, busy_d;

  // Frame state
  logic [4:0] bit_q, bit_d;
  logic [23:0] rx_q, rx_d;
  logic [15:0] tx_q, tx_d;
  logic miso_q, miso_d;
  logic wr_stb;
  logic [6:0] wr_addr;
  logic [15:0] wr_data;

  function automatic logic [15:0] read_mux(input logic [6:0] addr,
      input dcr_pkg::dcr_code_t c0, input dcr_pkg::dcr_code_t c1,
      input dcr_pkg::dcr_code_t lo, input dcr_pkg::dcr_code_t hi,
      input logic [15:0] rp);
    logic [15:0] val;
    val = 16'h0000;
    case (addr)
      `DCR_OFF_CODE_CH0: val = {c0, 4'h0};
      `DCR_OFF_CODE_CH1: val = {c1, 4'h0};
      `DCR_OFF_LOW_CH2: val = {lo, 4'h0};
      `DCR_OFF_HIGH_CH2: val = {hi, 4'h0};
      `DCR_OFF_RAMP_CH2: val = rp;
      default: val = 16'h0000;
    endcase
    return val;
  endfunction

  always_comb begin
    bit_d = bit_q;
    rx_d = rx_q;
    tx_d = tx_q;
    miso_d = miso_q;
    wr_stb = 1'b0;
    if (cs_s2_q) begin
      bit_d = 5'd0;
    end else if (sclk_rise) begin
      rx_d = {rx_q[22:0], mosi_s2_q};
      bit_d = bit_q + 5'd1;
      // Address complete: latch read data so it leaves on the next falling edges
      if (bit_q == 5'd7) begin
        tx_d = read_mux(rx_d[6:0], code0_q, code1_q, low_q, high_q, ramp_q);
      end
      if (bit_q == 5'(`DCR_FRAME_BITS - 1)) begin
        wr_stb = ~rx_d[`DCR_RD_BIT];
      end
    end else if (sclk_fall) begin
      miso_d = tx_q[15];
      tx_d = {tx_q[14:0], 1'b0};
    end
  end

  assign wr_addr = rx_d[22:16];
  assign wr_data = rx_d[15:0];

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      bit_q <= 5'd0;
      rx_q <= 24'h000000;
      tx_q <= 16'h0000;
      miso_q <= 1'b0;
    end else begin
      bit_q <= bit_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      miso_q <= miso_d;
    end
  end

  // Ramp step interval lookup
  logic [2:0] step_sel;
  logic [16:0] step_cyc;
  logic [12:0] step_amt, up_val;
  dcr_pkg::dcr_code_t target;
  logic dir_up, ramp_en;

  always_comb begin
    dir_up = ramp_q[`DCR_DIR_BIT];
    ramp_en = ramp_q[`DCR_LOGEN_BIT];
    target = dir_up ? high_q : low_q;
    step_sel = dir_up ? ramp_q[`DCR_RISE_MSB:`DCR_RISE_LSB]
                      : ramp_q[`DCR_FALL_MSB:`DCR_FALL_LSB];
    case (step_sel)
      3'b000: step_cyc = 17'(STEP_CYC_0);
      3'b001: step_cyc = 17'(STEP_CYC_1);
      3'b010: step_cyc = 17'(STEP_CYC_2);
      3'b011: step_cyc = 17'(STEP_CYC_3);
      3'b100: step_cyc = 17'(STEP_CYC_4);
      default: step_cyc = 17'(STEP_CYC_5);
    endcase
    // One step is 1/32 of the present code, never less than one LSB
    step_amt = {1'b0, code2_q >> `DCR_LOG_SHIFT} & {1'b0, CODE_MASK};
    if (step_amt == 13'd0) begin
      step_amt = {1'b0, ~CODE_MASK + 12'h001};
    end
    up_val = {1'b0, code2_q} + step_amt;
  end

  always_comb begin
    code0_d = code0_q;
    code1_d = code1_q;
    low_d = low_q;
    high_d = high_q;
    ramp_d = ramp_q;
    code2_d = code2_q;
    tick_d = tick_q;
    busy_d = ramp_en && (code2_q != target);
    if (wr_stb) begin
      case (wr_addr)
        `DCR_OFF_CODE_CH0: code0_d = wr_data[15:4] & CODE_MASK;
        `DCR_OFF_CODE_CH1: code1_d = wr_data[15:4] & CODE_MASK;
        `DCR_OFF_LOW_CH2: low_d = wr_data[15:4] & CODE_MASK;
        `DCR_OFF_HIGH_CH2: high_d = wr_data[15:4] & CODE_MASK;
        `DCR_OFF_RAMP_CH2: ramp_d = wr_data & 16'h80fe;
        default: ramp_d = ramp_q;
      endcase
    end
    if (!ramp_en || code2_q == target) begin
      tick_d = 17'd0;
    end else if (tick_q >= step_cyc - 17'd1) begin
      tick_d = 17'd0;
      if (dir_up) begin
        if (code2_q == 12'h000 && target != 12'h000) begin
          code2_d = ~CODE_MASK + 12'h001;
        end else if (up_val > {1'b0, target}) begin
          code2_d = target;
        end else begin
          code2_d = up_val[11:0];
        end
      end else if ({1'b0, code2_q} < {1'b0, target} + step_amt) begin
        code2_d = target;
      end else begin
        code2_d = code2_q - step_amt[11:0];
      end
    end else begin
      tick_d = tick_q + 17'd1;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      code0_q <= 12'(`DCR_CODE_RST >> `DCR_CODE_LSB);
      code1_q <= 12'(`DCR_CODE_RST >> `DCR_CODE_LSB);
      low_q <= 12'h000;
      high_q <= 12'h000;
      ramp_q <= `DCR_RAMP_RST;
      code2_q <= 12'h000;
      tick_q <= 17'd0;
      busy_q <= 1'b0;
    end else begin
      code0_q <= code0_d;
      code1_q <= code1_d;
      low_q <= low_d;
      high_q <= high_d;
      ramp_q <= ramp_d;
      code2_q <= code2_d;
      tick_q <= tick_d;
      busy_q <= busy_d;
    end
  end

  assign LINK.miso = miso_q;
  assign CODE_CH0_O = code0_q[11 -: CODE_BITS];
  assign CODE_CH1_O = code1_q[11 -: CODE_BITS];
  assign CODE_CH2_O = code2_q[11 -: CODE_BITS];
  assign RAMP_BUSY_O = busy_q;

endmodule // dcr_device

//--- rtl/dcr_host.sv
// Controller end: Wishbone command registers driving the serial link
`timescale 1ns/10ps
`include "dcr_regs.svh"
module dcr_host #(
  parameter int HALF_CYC = `DCR_HALF_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  dcr_link_if.host LINK
);

  dcr_pkg::dcr_host_state_t state_q, state_d;
  logic [7:0] div_q, div_d;
  logic [4:0] bit_q, bit_d;
  logic [23:0] sh_q, sh_d;
  logic sclk_q, sclk_d, cs_n_q, cs_n_d, mosi_q, mosi_d;
  logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic done_q, done_d, ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic miso_s1_q, miso_s2_q;
  logic req, wr;

  assign req = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wr = req & WB_WE_I;

  always_comb begin
    state_d = state_q;
    div_d = div_q;
    bit_d = bit_q;
    sh_d = sh_q;
    sclk_d = sclk_q;
    cs_n_d = cs_n_q;
    mosi_d = mosi_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    done_d = done_q;
    ack_d = req;
    dat_d = dat_q;
    if (wr && WB_ADR_I == `DCR_WB_WDATA) begin
      if (WB_SEL_I[0]) wdata_d[7:0] = WB_DAT_I[7:0];
      if (WB_SEL_I[1]) wdata_d[15:8] = WB_DAT_I[15:8];
    end
    if (wr && WB_ADR_I == `DCR_WB_STAT && WB_SEL_I[0] && WB_DAT_I[`DCR_STAT_DONE_BIT]) begin
      done_d = 1'b0;
    end
    if (req && !WB_WE_I) begin
      case (WB_ADR_I)
        `DCR_WB_WDATA: dat_d = {16'h0000, wdata_q};
        `DCR_WB_RDATA: dat_d = {16'h0000, rdata_q};
        `DCR_WB_STAT: dat_d = {30'h00000000, done_q, state_q != dcr_pkg::DCR_H_IDLE};
        default: dat_d = 32'h00000000;
      endcase
    end
    case (state_q)
      dcr_pkg::DCR_H_IDLE: begin
        // Code words are written left-aligned by software in bits 15-4
        if (wr && WB_ADR_I == `DCR_WB_CMD && WB_SEL_I[1:0] == 2'b11) begin
          sh_d = {WB_DAT_I[`DCR_CMD_RD_BIT], WB_DAT_I[6:0], wdata_q};
          mosi_d = WB_DAT_I[`DCR_CMD_RD_BIT];
          cs_n_d = 1'b0;
          div_d = 8'd0;
          bit_d = 5'd0;
          state_d = dcr_pkg::DCR_H_SHIFT;
        end
      end
      dcr_pkg::DCR_H_SHIFT: begin
        div_d = div_q + 8'd1;
        if (div_q == 8'(HALF_CYC - 1)) begin
          div_d = 8'd0;
          if (!sclk_q) begin
            sclk_d = 1'b1;
            sh_d = {sh_q[22:0], miso_s2_q};
          end else begin
            sclk_d = 1'b0;
            bit_d = bit_q + 5'd1;
            mosi_d = sh_q[23];
            if (bit_q == 5'(`DCR_FRAME_BITS - 1)) begin
              cs_n_d = 1'b1;
              mosi_d = 1'b0;
              rdata_d = sh_q[15:0];
              state_d = dcr_pkg::DCR_H_GAP;
            end
          end
        end
      end
      dcr_pkg::DCR_H_GAP: begin
        div_d = div_q + 8'd1;
        if (div_q == 8'(HALF_CYC - 1)) begin
          div_d = 8'd0;
          done_d = 1'b1;
          state_d = dcr_pkg::DCR_H_IDLE;
        end
      end
      default: state_d = dcr_pkg::DCR_H_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      state_q <= dcr_pkg::DCR_H_IDLE;
      div_q <= 8'd0;
      bit_q <= 5'd0;
      sh_q <= 24'h000000;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      done_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end else begin
      state_q <= state_d;
      div_q <= div_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      sclk_q <= sclk_d;
      cs_n_q <= cs_n_d;
      mosi_q <= mosi_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
      miso_s1_q <= LINK.miso;
      miso_s2_q <= miso_s1_q;
    end
  end

  assign LINK.sclk = sclk_q;
  assign LINK.cs_n = cs_n_q;
  assign LINK.mosi = mosi_q;
  assign WB_DAT_O = dat_q;
  assign WB_ACK_O = ack_q;

endmodule // dcr_host

//--- bench/dcr_link_sva.sv
// Assertions on the serial link between controller and register bank
`timescale 1ns/10ps
module dcr_link_sva (
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);
  logic [4:0] rises_q;
  logic [4:0] rises_d;
  logic sclk_q;
  logic sclk_d;
  // Rising edges seen in the current frame
  always_comb begin
    sclk_d = SRST_I ? 1'b0 : sclk;
    rises_d = (SRST_I | cs_n) ? 5'h00 : rises_q + {4'h0, sclk & ~sclk_q};
  end
  always_ff @(posedge REF_CLK_I) begin
    sclk_q <= sclk_d;
    rises_q <= rises_d;
  end
  sequence s_half_high;
    sclk [*8];
  endsequence
  sequence s_half_low;
    !sclk [*8];
  endsequence
  property p_high_half;
    $rose(sclk) |-> s_half_high ##1 !sclk;
  endproperty
  property p_low_half;
    ($fell(sclk) && rises_q < 5'h18) |-> s_half_low ##1 sclk;
  endproperty
  property p_frame_start;
    $fell(cs_n) |-> s_half_low ##1 sclk;
  endproperty
  property p_idle_clk;
    cs_n |-> !sclk;
  endproperty
  property p_idle_miso;
    cs_n |-> !miso;
  endproperty
  property p_mosi_held;
    sclk |-> $stable(mosi);
  endproperty
  property p_miso_held;
    sclk |-> $stable(miso);
  endproperty
  property p_frame_len;
    $rose(cs_n) |-> rises_q == 5'h18;
  endproperty
  a_high_half: assert property (p_high_half) else $error("sclk high half wrong");
  a_low_half: assert property (p_low_half) else $error("sclk low half wrong");
  a_frame_start: assert property (p_frame_start) else $error("first rise late");
  a_idle_clk: assert property (p_idle_clk) else $error("sclk moves idle");
  a_idle_miso: assert property (p_idle_miso) else $error("miso not low idle");
  a_mosi_held: assert property (p_mosi_held) else $error("mosi moved high");
  a_miso_held: assert property (p_miso_held) else $error("miso moved high");
  a_frame_len: assert property (p_frame_len) else $error("frame not 24 bits");
endmodule // dcr_link_sva

//--- bench/tb_dac_code_registers.sv
// Testbench: Wishbone host drives the code register bank over the link
`timescale 1ns/10ps
`include "dcr_regs.svh"
module tb_dac_code_registers;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [9:0] c0;
  logic [9:0] c1;
  logic [9:0] c2;
  logic busy;
  int failures = 0;
  int comparisons = 0;
  int seed = 32'h14aa;
  // Code 000 keeps its real interval; the others are shortened to keep the run brief
  int steps [6] = '{`DCR_NS_TO_CYC(`DCR_STEP0_NS), 8, 12, 16, 20, 24};
  logic [15:0] model [128] = '{default: 16'h0000};
  dcr_link_if link();
  dcr_device #(.STEP_CYC_1(8), .STEP_CYC_2(12), .STEP_CYC_3(16), .STEP_CYC_4(20),
    .STEP_CYC_5(24)) u_dcr_device (
    .REF_CLK_I(clk), .SRST_I(rst), .LINK(link), .CODE_CH0_O(c0),
    .CODE_CH1_O(c1), .CODE_CH2_O(c2), .RAMP_BUSY_O(busy));
  dcr_host u_dcr_host (.REF_CLK_I(clk), .SRST_I(rst),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .LINK(link));
  dcr_link_sva u_dcr_link_sva (.REF_CLK_I(clk), .SRST_I(rst), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));
  always #2 clk = ~clk;

  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) failures++;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    @(posedge clk);
  endtask

  function automatic logic [15:0] msk(input logic [6:0] a);
    case (a)
      7'h1b, 7'h1c, 7'h13, 7'h14: return 16'hffc0;
      7'h18: return 16'h80fe;
      default: return 16'h0000;
    endcase
  endfunction

  // One link frame; status is polled until the done bit sets after the 24-bit frame
  task automatic dev(input logic w, input logic [6:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    logic [31:0] r;
    int n;
    wb(1'b1, 8'h04, {16'h0000, d}, r);
    wb(1'b1, 8'h00, {23'h000000, ~w, 1'b0, a}, r);
    n = 0;
    do begin
      wb(1'b0, 8'h0c, 32'h0, r);
      n++;
    end while (r[1] !== 1'b1 && n < 300);
    if (n >= 300) failures++;
    wb(1'b1, 8'h0c, 32'h2, r);
    wb(1'b0, 8'h08, 32'h0, r);
    q = r[15:0];
    if (w) model[a] = d & msk(a);
  endtask

  task automatic rd(input logic [6:0] a);
    logic [15:0] q;
    dev(1'b0, a, 16'h0000, q);
    chk("readback", {16'h0, model[a]}, {16'h0, q});
  endtask

  task automatic settle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
  endtask

  initial begin
    logic [15:0] q;
    logic [15:0] d;
    logic [31:0] r;
    logic [9:0] v;
    int n;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("code0", 32'h0, {22'h0, c0});
    chk("code1", 32'h0, {22'h0, c1});
    rd(7'h1c);
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 16'hffff : (k == 1) ? 16'h000f : 16'($random(seed));
      dev(1'b1, k[1] ? 7'h1c : 7'h1b, d, q);
      chk("code0", {22'h0, model[7'h1b][15:6]}, {22'h0, c0});
      chk("code1", {22'h0, model[7'h1c][15:6]}, {22'h0, c1});
      rd(k[1] ? 7'h1c : 7'h1b);
    end
    $display("test codes done");
    dev(1'b1, 7'h05, 16'hffff, q);
    rd(7'h05);
    wb(1'b0, 8'h10, 32'h0, r);
    chk("unmapped", 32'h0, r);
    $display("test unmapped done");
    dev(1'b1, 7'h13, 16'h0000, q);
    dev(1'b1, 7'h14, 16'hffc0, q);
    dev(1'b1, 7'h18, 16'hffff, q);
    rd(7'h18);
    for (int k = 0; k < 6; k++) begin
      // The slow code 000 gets a short ramp, only three steps long
      dev(1'b1, 7'h13, (k == 0) ? 16'hf000 : 16'h0000, q);
      dev(1'b1, 7'h18, 16'h8090, q);
      settle();
      chk("ramp top", {22'h0, model[7'h14][15:6]}, {22'h0, c2});
      chk("busy", 32'h0, {31'h0, busy});
      dev(1'b1, 7'h18, {12'h008, k[2:0], 1'b0}, q);
      for (int m = 0; m < 2; m++) begin
        v = c2;
        n = 0;
        while (c2 === v && n < 2000) begin
          @(posedge clk);
          n++;
        end
      end
      chk("fall step", steps[k], n);
      settle();
      chk("ramp bottom", {22'h0, model[7'h13][15:6]}, {22'h0, c2});
    end
    $display("test ramp done");
    end_of_test();
  end

  // Whole run needs roughly 40000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule // tb_dac_code_registers
